// >>> design/hpl_port.sv
// Parallel host port: register access, auto-increment, pre-read and LCD pass-through
//
// Contract
// - Classify host accesses: register write, register read, LCD write, LCD read.
// - Internal accesses carry 16-bit data, 12-bit address, one-cycle strobe.
// - Write with select low loads the address register, no bus write.
// - Write with select high writes the register at the stored address.
// - At end of data write, one-cycle write strobe with address and data.
// - Stored address increments after each data access.
// - No increment while address bits [11:8] equal the memory prefix.
// - Reads use the last loaded address or its incremented value.
// - Select ignored on reads; host must never read with select low.
// - A configuration bit chooses normal or pre-read mode.
// - Normal mode: each host read triggers an internal read, returned on pins.
// - Pre-read: address load starts a read; each data read launches next.
// - Two LCDs; LCD access drives the chip select picked by panel choice.
// - LCD pass-through is purely combinational, works without the clock.
// - Outside chip-select mode, route select low sends host data to video bits [9:2], write to valid.
// - Only writes with LCD chip select active reach the valid pin; raw host_write_n is passed, so Motorola-style LCD reads pulse it too.
// - Register 0x108 holds external chip-select mode and frame-aligned output enable.
// - In chip-select mode, route select low drives video bits [9:1], else tri-state.
// - Qualified clock: qualify gated with clock, polarity set, frame-valid gated.
// - Option one: all strobes on valid, clock pin zero; option two splits bytes.
`timescale 1ns/1ps
module hpl_port
  import hpl_pkg::*;
(
  input  wire logic               mclk,                   // core clock, 250 MHz
  input  wire logic               rst,                    // sync reset, high
  input  wire logic [15:0]        host_data_i,            // host data pins in
  output logic      [15:0]        host_data_o,            // host data pins out
  output logic                    host_data_oe_n,         // low while driving
  input  wire logic               addr_data_select,       // 0 address, 1 data
  input  wire logic               host_write_n,           // write, or host_strobe_n
  input  wire logic               host_read_n,            // read, or host_rw_n
  input  wire logic               host_select_n,          // port chip select
  input  wire logic               panel_choice_n,           // LCD chip select
  input  wire logic               baseband_route_sel,     // LCD route select
  input  wire logic               motorola_style_bus,     // 1 strobe plus rw
  output hpl_pkg::hpl_ibus_t      ibus_o,                 // internal control bus
  input  wire logic [15:0]        ibus_rdata,             // read data, cycle after rd
  input  wire logic [9:0]         pvi_data,               // device video data
  input  wire logic               pvi_valid,              // device qualify
  input  wire logic               pvi_clk,                // device output clock level
  input  wire logic               pvi_frame_valid,        // frame active
  input  wire logic               pvi_byte_stb,           // one pulse per byte
  output logic      [9:0]         video_dout_o,           // video data out
  output logic      [9:0]         video_dout_oe_n,        // low while driving
  output logic                    video_valid_out,        // valid / LCD write
  output logic                    video_clock_out,        // video clock pin
  output logic                    frame_valid,            // frame valid pin
  output logic      [1:0]         panel_select_outputs_n, // LCD chip selects
  output hpl_pkg::hpl_op_t        op_class                // last access class
);
  // ==========================================================
  // State
  typedef struct packed {
    hpl_ph_t           ph;
    hpl_op_t           op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] hold;
    logic [DATA_W-1:0] osc;
    logic [DATA_W-1:0] mode;
    hpl_ibus_t         bus;
    logic              cap;
    logic [ADDR_W-1:0] cap_addr;
    logic              en_eff;
    logic              byte_odd;
  } hpl_state_t;

  hpl_state_t s_q;
  hpl_state_t s_d;
  hpl_hpin_t  hs;
  hpl_vctl_t  vctl;
  logic       wr_act;
  logic       rd_act;
  logic       lcd_wr;
  logic       lcd_rd;
  logic       preread;

  // ==========================================================
  // Pin synchronisation
  hpl_sync #(.W($bits(hpl_hpin_t)), .RST(HPIN_IDLE)) u_sync (
    .mclk (mclk),
    .rst  (rst),
    .d    ({motorola_style_bus, host_write_n, host_read_n, host_select_n,
            panel_choice_n, addr_data_select, host_data_i}),
    .q    (hs)
  );

  // Intel style: separate strobes; Motorola style: strobe plus direction
  assign wr_act  = !hs.cs_n && !hs.wr_n && (hs.m68 ? !hs.rd_n : 1'b1);
  assign rd_act  = !hs.cs_n && (hs.m68 ? (!hs.wr_n && hs.rd_n) : !hs.rd_n);
  assign lcd_wr  = !hs.lcd_n && !hs.wr_n && (hs.m68 ? !hs.rd_n : 1'b1);
  assign lcd_rd  = !hs.lcd_n && (hs.m68 ? (!hs.wr_n && hs.rd_n) : !hs.rd_n);
  assign preread = s_q.mode[MODE_PREREAD];

  // ==========================================================
  // Access sequencing
  always_comb begin
    s_d = s_q;
    s_d.bus.wr = 1'b0;
    s_d.bus.rd = 1'b0;
    s_d.cap = s_q.bus.rd;
    if (s_q.bus.rd) begin
      s_d.cap_addr = s_q.bus.addr;
    end
    case (s_q.ph)
      PH_IDLE: begin
        if (wr_act) begin
          s_d.ph = PH_WRITE;
          s_d.op = OP_REG_WR;
        end else if (rd_act) begin
          // Select pin plays no part in a read
          s_d.ph = PH_READ;
          s_d.op = OP_REG_RD;
          if (!preread) begin
            s_d.bus.rd = 1'b1;
            s_d.bus.addr = s_q.addr;
          end
        end else if (lcd_wr) begin
          s_d.op = OP_LCD_WR;
        end else if (lcd_rd) begin
          s_d.op = OP_LCD_RD;
        end
      end
      PH_WRITE: begin
        if (!wr_act) begin
          s_d.ph = PH_IDLE;
          if (hs.ads) begin
            s_d.bus.wr = 1'b1;
            s_d.bus.addr = s_q.addr;
            s_d.bus.wdata = hs.data;
            s_d.addr = hpl_next_addr(s_q.addr);
            if (s_q.addr == OSC_OFFSET) begin
              s_d.osc = hs.data;
            end else if (s_q.addr == MODE_OFFSET) begin
              s_d.mode = hs.data;
            end
          end else begin
            s_d.addr = hs.data[ADDR_W-1:0];
            if (preread) begin
              s_d.bus.rd = 1'b1;
              s_d.bus.addr = hs.data[ADDR_W-1:0];
            end
          end
        end
      end
      PH_READ: begin
        // Advance only when the host lets go, so the held word stays put
        if (!rd_act) begin
          s_d.ph = PH_IDLE;
          s_d.addr = hpl_next_addr(s_q.addr);
          if (preread) begin
            s_d.bus.rd = 1'b1;
            s_d.bus.addr = hpl_next_addr(s_q.addr);
          end
        end
      end
      default: s_d.ph = PH_IDLE;
    endcase
    if (s_q.cap) begin
      if (s_q.cap_addr == OSC_OFFSET) begin
        s_d.hold = s_q.osc;
      end else if (s_q.cap_addr == MODE_OFFSET) begin
        s_d.hold = s_q.mode;
      end else begin
        s_d.hold = ibus_rdata;
      end
    end
    // Output enable changes only between frames
    if (!pvi_frame_valid) begin
      s_d.en_eff = s_q.osc[OSC_EN_OUT];
      s_d.byte_odd = 1'b0;
    end else if (pvi_byte_stb) begin
      s_d.byte_odd = !s_q.byte_odd;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_q <= '{ph: PH_IDLE, op: OP_IDLE, addr: 12'h000, hold: 16'h0000,
               osc: OSC_RESET, mode: MODE_RESET, bus: '0, cap: 1'b0,
               cap_addr: 12'h000, en_eff: 1'b0, byte_odd: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs
  assign ibus_o      = s_q.bus;
  assign op_class    = s_q.op;
  assign host_data_o = s_q.hold;
  assign frame_valid = pvi_frame_valid;
  // Enable follows the pins directly so the bus turns around without delay
  assign host_data_oe_n = host_select_n ||
                          (motorola_style_bus ? (host_write_n || !host_read_n)
                                              : host_read_n);
  assign vctl = '{ext_cs: s_q.osc[OSC_EXT_CS], en_eff: s_q.en_eff,
                  qclk_en: s_q.osc[OSC_QCLK_EN], qclk_pol: s_q.osc[OSC_QCLK_POL],
                  qclk_split: s_q.osc[OSC_QCLK_SPLIT]};

  // Kept clock-free so the LCD stays reachable with mclk stopped
  hpl_lcd_route u_route (
    .ctl                    (vctl),
    .panel_choice           (s_q.mode[MODE_PANEL]),
    .host_data_lo           (host_data_i[7:0]),
    .host_write_n           (host_write_n),
    .panel_choice_n           (panel_choice_n),
    .baseband_route_sel     (baseband_route_sel),
    .pvi_data               (pvi_data),
    .pvi_valid              (pvi_valid),
    .pvi_clk                (pvi_clk),
    .pvi_frame_valid        (pvi_frame_valid),
    .byte_odd               (s_q.byte_odd),
    .video_dout_o           (video_dout_o),
    .video_dout_oe_n        (video_dout_oe_n),
    .video_valid_out        (video_valid_out),
    .video_clock_out        (video_clock_out),
    .panel_select_outputs_n (panel_select_outputs_n)
  );

  // ==========================================================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  chk_wr_one_cycle: assert property (ibus_o.wr |=> !ibus_o.wr [*2])
    else $error("write strobe longer than one cycle or repeated");
  chk_rd_one_cycle: assert property (ibus_o.rd |=> !ibus_o.rd)
    else $error("read strobe longer than one cycle");
  chk_addr_load_quiet: assert property (
    (s_q.ph == PH_WRITE && !wr_act && !hs.ads)
      |=> !ibus_o.wr && s_q.addr == $past(hs.data[ADDR_W-1:0]))
    else $error("address load caused a write or lost the address");
  chk_data_write: assert property (
    (s_q.ph == PH_WRITE && !wr_act && hs.ads)
      |=> ibus_o.wr && ibus_o.addr == $past(s_q.addr)
          && ibus_o.wdata == $past(hs.data))
    else $error("data write strobe, address or data wrong");
  chk_auto_incr: assert property (
    (ibus_o.wr && ibus_o.addr[11:8] != MEM_PREFIX)
      |-> s_q.addr == ADDR_W'(ibus_o.addr + 12'h001))
    else $error("address did not increment");
  chk_mem_hold: assert property (
    (ibus_o.wr && ibus_o.addr[11:8] == MEM_PREFIX) |-> s_q.addr == ibus_o.addr)
    else $error("memory section address incremented");
  chk_normal_read: assert property (
    (s_q.ph == PH_IDLE && !wr_act && rd_act && !preread)
      |=> ibus_o.rd && ibus_o.addr == $past(s_q.addr))
    else $error("normal read did not start internal read");
  chk_hold_capture: assert property (
    (ibus_o.rd && ibus_o.addr != OSC_OFFSET && ibus_o.addr != MODE_OFFSET)
      |=> ##1 s_q.hold == $past(ibus_rdata))
    else $error("read data not captured");
  chk_preread_launch: assert property (
    (s_q.ph == PH_WRITE && !wr_act && !hs.ads && preread)
      |=> ibus_o.rd && ibus_o.addr == $past(hs.data[ADDR_W-1:0]))
    else $error("pre-read not launched after address load");
  chk_panel_pick: assert property (
    !panel_choice_n |-> panel_select_outputs_n[s_q.mode[MODE_PANEL]] == 1'b0)
    else $error("wrong LCD chip select");
  chk_direct_write: assert property (
    (!s_q.osc[OSC_EXT_CS] && !baseband_route_sel)
      |-> video_dout_o[9:2] == host_data_i[7:0]
          && video_valid_out == (host_write_n || panel_choice_n))
    else $error("direct LCD route wrong");

  cov_data_write: cover property (ibus_o.wr);
  cov_preread: cover property (preread && s_q.ph == PH_READ ##1 ibus_o.rd);
  cov_lcd_read: cover property (s_q.op == OP_LCD_RD);
endmodule

// >>> design/hpl_pkg.sv
// Package for the host port with LCD pass-through: constants, carriers, shared functions
package hpl_pkg;

  // ==========================================================
  // Widths and internal address map
  localparam int          ADDR_W       = 12;
  localparam int          DATA_W       = 16;
  localparam logic [11:0] OSC_OFFSET   = 12'h108;  // output_select_control
  localparam logic [11:0] MODE_OFFSET  = 12'h10A;  // read mode and panel choice
  localparam logic [3:0]  MEM_PREFIX   = 4'hF;     // memory section, bits [11:8]
  localparam logic [15:0] OSC_RESET    = 16'h0000;
  localparam logic [15:0] MODE_RESET   = 16'h0000;

  // ==========================================================
  // Field positions
  localparam int OSC_EXT_CS     = 0;
  localparam int OSC_EN_OUT     = 1;
  localparam int OSC_QCLK_EN    = 2;
  localparam int OSC_QCLK_POL   = 3;
  localparam int OSC_QCLK_SPLIT = 4;
  localparam int MODE_PREREAD   = 0;
  localparam int MODE_PANEL     = 1;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } hpl_ibus_t;

  typedef struct packed {
    logic              m68;
    logic              wr_n;
    logic              rd_n;
    logic              cs_n;
    logic              lcd_n;
    logic              ads;
    logic [DATA_W-1:0] data;
  } hpl_hpin_t;

  localparam hpl_hpin_t HPIN_IDLE = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 16'h0000};

  typedef struct packed {
    logic ext_cs;
    logic en_eff;
    logic qclk_en;
    logic qclk_pol;
    logic qclk_split;
  } hpl_vctl_t;

  typedef enum logic [2:0] {OP_IDLE, OP_REG_WR, OP_REG_RD, OP_LCD_WR, OP_LCD_RD} hpl_op_t;
  typedef enum logic [1:0] {PH_IDLE, PH_WRITE, PH_READ} hpl_ph_t;

  // Auto-increment, held still inside the memory section
  function automatic logic [ADDR_W-1:0] hpl_next_addr(input logic [ADDR_W-1:0] a);
    hpl_next_addr = (a[11:8] == MEM_PREFIX) ? a : ADDR_W'(a + 12'h001);
  endfunction

endpackage

// >>> design/hpl_sync.sv
// Two-stage synchroniser for a group of host pins
`timescale 1ns/1ps
module hpl_sync #(
  parameter int              W   = 1,
  parameter logic [W-1:0]    RST = '0
) (
  input  wire logic         mclk,  // core clock
  input  wire logic         rst,   // sync reset, high
  input  wire logic [W-1:0] d,     // asynchronous pins
  output logic      [W-1:0] q      // synchronised copy
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } hpl_sync_st_t;

  hpl_sync_st_t s_q;
  hpl_sync_st_t s_d;

  always_comb begin
    s_d.s1 = d;
    s_d.s2 = s_q.s1;
  end

  // Reset to idle levels so no access is seen while the stages fill
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_q <= {RST, RST};
    end else begin
      s_q <= s_d;
    end
  end

  assign q = s_q.s2;
endmodule

// >>> design/hpl_lcd_route.sv
// Clock-free routing of host and video signals to the LCD and video pins
`timescale 1ns/1ps
module hpl_lcd_route
  import hpl_pkg::*;
(
  input  wire hpl_pkg::hpl_vctl_t ctl,                    // video output control
  input  wire logic               panel_choice,           // 0 first LCD, 1 second
  input  wire logic [7:0]         host_data_lo,           // host data bits [7:0]
  input  wire logic               host_write_n,           // host write pin
  input  wire logic               panel_choice_n,           // host LCD chip select
  input  wire logic               baseband_route_sel,     // 0 routes host to LCD; with ext_cs, 0 enables video bits [9:1]
  input  wire logic [9:0]         pvi_data,               // device video data
  input  wire logic               pvi_valid,              // device qualify
  input  wire logic               pvi_clk,                // device output clock level
  input  wire logic               pvi_frame_valid,        // frame active
  input  wire logic               byte_odd,               // odd byte of a pair
  output logic      [9:0]         video_dout_o,           // video data out
  output logic      [9:0]         video_dout_oe_n,        // low while driving
  output logic                    video_valid_out,        // valid / LCD write pin
  output logic                    video_clock_out,        // video clock pin
  output logic      [1:0]         panel_select_outputs_n  // LCD chip selects
);
  logic direct;
  logic qual;
  logic drive;
  logic line_q;

  always_comb begin
    direct = !ctl.ext_cs && !baseband_route_sel;
    video_dout_o = direct ? {host_data_lo, pvi_data[1:0]} : pvi_data;
    qual = pvi_valid && pvi_frame_valid && pvi_clk;
    line_q = (ctl.qclk_split ? (qual && byte_odd) : qual) ^ ctl.qclk_pol;
    if (!ctl.qclk_en) begin
      line_q = pvi_valid;
      video_clock_out = pvi_clk;
    end else if (ctl.qclk_split) begin
      video_clock_out = (qual && !byte_odd) ^ ctl.qclk_pol;
    end else begin
      video_clock_out = 1'b0;
    end
    // Write pulse only when the host addresses the LCD
    video_valid_out = direct ? (host_write_n || panel_choice_n) : line_q;
    drive = ctl.ext_cs ? !baseband_route_sel : (ctl.en_eff || direct);
    video_dout_oe_n = {10{!drive}};
    if (ctl.ext_cs) begin
      video_dout_oe_n[0] = 1'b1;
    end
    panel_select_outputs_n = panel_choice_n ? 2'b11 :
                             (panel_choice ? 2'b01 : 2'b10);
  end
endmodule

// >>> verif/hpl_ibus_model.sv
// Behavioural register and memory responder on the internal control bus
`timescale 1ns/1ps
module hpl_ibus_model (
  input  wire logic               mclk,  // core clock
  input  wire hpl_pkg::hpl_ibus_t ibus,  // requests from the port
  output logic [15:0]             rdata  // read data, cycle after rd
);
  import hpl_pkg::*;
  logic [15:0] mem [4096];

  initial begin
    for (int i = 0; i < 4096; i++) mem[i] = 16'(i) ^ 16'hA5A5;
    rdata = 16'h0000;
  end

  // Outside the answer cycle the data toggles, so a late sample cannot pass
  always @(posedge mclk) begin
    if (ibus.wr) mem[ibus.addr] <= ibus.wdata;
    rdata <= ibus.rd ? mem[ibus.addr] : ~rdata;
  end
endmodule

// >>> verif/hpl_port_tb.sv
// Self-checking bench for the host port and its LCD pass-through
`timescale 1ns/1ps
module hpl_port_tb;
  import hpl_pkg::*;
  logic        mclk, rst, ads, wr_n, rd_n, cs_n, lcd_n, bb, m68, pre;
  logic        hd_oe_n, vvalid, vclk, fvalid, p_valid, p_clk, p_fv, bs;
  logic [15:0] hd_drv, hd_o, rdata;
  logic [15:0] shadow [4096];
  logic [9:0]  p_data, dout, dout_oe_n;
  logic [1:0]  psel_n;
  logic [11:0] ap;
  logic [27:0] wq [$];
  logic [27:0] rq [$];
  hpl_ibus_t   ibus;
  hpl_op_t     opc;
  int          num_errors, checked;
  wire  [15:0] hd_i = hd_oe_n ? hd_drv : hd_o;

  always #2 mclk = ~mclk;

  hpl_port dut (.mclk(mclk), .rst(rst), .host_data_i(hd_i), .host_data_o(hd_o),
    .host_data_oe_n(hd_oe_n), .addr_data_select(ads), .host_write_n(wr_n),
    .host_read_n(rd_n), .host_select_n(cs_n), .panel_choice_n(lcd_n),
    .baseband_route_sel(bb), .motorola_style_bus(m68), .ibus_o(ibus),
    .ibus_rdata(rdata), .pvi_data(p_data), .pvi_valid(p_valid), .pvi_clk(p_clk),
    .pvi_frame_valid(p_fv), .pvi_byte_stb(bs), .video_dout_o(dout),
    .video_dout_oe_n(dout_oe_n), .video_valid_out(vvalid), .video_clock_out(vclk),
    .frame_valid(fvalid), .panel_select_outputs_n(psel_n), .op_class(opc));

  hpl_ibus_model ibm (.mclk(mclk), .ibus(ibus), .rdata(rdata));

  // ==========================================
  // Checking and closing
  task automatic check(input logic [27:0] seen, input logic [27:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  function automatic logic [11:0] step(input logic [11:0] a);
    return (a[11:8] == MEM_PREFIX) ? a : a + 12'h001;
  endfunction

  always @(posedge mclk) begin
    if (!rst && ibus.wr) begin
      if (wq.size() == 0) check(28'h1, 28'h0);
      else check({ibus.addr, ibus.wdata}, wq.pop_front());
    end
    if (!rst && ibus.rd) begin
      if (rq.size() == 0) check(28'h1, 28'h0);
      else check({ibus.addr, 16'h0000}, rq.pop_front());
    end
  end

  // ==========================================
  // Host accesses; strobes held well past the synchroniser depth
  task automatic acc(input logic wr, input logic sel, input logic [15:0] d,
                     output logic [15:0] q);
    @(posedge mclk);
    cs_n <= 1'b0;
    ads <= sel;
    hd_drv <= d;
    rd_n <= m68 ? ~wr : 1'b1;
    @(posedge mclk);
    if (wr || m68) wr_n <= 1'b0;
    else rd_n <= 1'b0;
    repeat (8) @(posedge mclk);
    q = hd_o;
    if (!wr) check(28'(hd_oe_n), 28'h0);
    wr_n <= 1'b1;
    if (!m68) rd_n <= 1'b1;
    @(posedge mclk);
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    for (int i = 0; i < 20 && wq.size() + rq.size() > 0; i++) @(posedge mclk);
    if (wq.size() + rq.size() > 0) begin
      num_errors++;
      $display("mismatch at %0t: bus access missing", $time);
      stop_test();
    end
    repeat (2) @(posedge mclk);
  endtask

  task automatic load(input logic [11:0] a);
    logic [15:0] q;
    ap = a;
    if (pre) rq.push_back({a, 16'h0000});
    acc(1'b1, 1'b0, {4'h0, a}, q);
  endtask

  task automatic wdat(input logic [15:0] d);
    logic [15:0] q;
    wq.push_back({ap, d});
    shadow[ap] = d;
    ap = step(ap);
    acc(1'b1, 1'b1, d, q);
    check(28'(opc), 28'(OP_REG_WR));
  endtask

  task automatic rdat();
    logic [15:0] q;
    logic [15:0] e;
    e = shadow[ap];
    if (!pre) rq.push_back({ap, 16'h0000});
    ap = step(ap);
    if (pre) rq.push_back({ap, 16'h0000});
    acc(1'b0, 1'b1, 16'h0000, q);
    check(28'(q), 28'(e));
    check(28'(opc), 28'(OP_REG_RD));
  endtask

  task automatic wreg(input logic [11:0] a, input logic [15:0] d);
    load(a);
    wdat(d);
  endtask

  // ==========================================
  // Scenarios
  initial begin
    {ads, m68, bb, pre, p_valid, p_clk, p_fv, bs} = '0;
    {wr_n, rd_n, cs_n, lcd_n, rst, mclk} = '1;
    mclk = 1'b0;
    hd_drv = 16'h0000;
    p_data = 10'h000;
    num_errors = 0;
    checked = 0;
    bb = 1'b1;
    for (int i = 0; i < 4096; i++) shadow[i] = 16'(i) ^ 16'hA5A5;
    shadow[OSC_OFFSET] = OSC_RESET;
    shadow[MODE_OFFSET] = MODE_RESET;
    void'($urandom(47324));
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    check({ibus.wr, ibus.rd, 23'h0, opc}, {25'h0, OP_IDLE});
    load(OSC_OFFSET);
    rdat();
    rdat();
    $display("test reset done");
    for (int m = 0; m < 2; m++) begin
      m68 <= m[0];
      load(12'hEFE);
      repeat (4) wdat(16'($urandom));
      load(12'hEFE);
      repeat (3) rdat();
    end
    $display("test auto increment done");
    for (int p = 0; p < 2; p++) begin
      wreg(MODE_OFFSET, {14'h0, p[0], 1'b0});
      @(posedge mclk);
      lcd_n <= 1'b0;
      bb <= 1'b0;
      hd_drv <= 16'($urandom);
      p_data <= 10'($urandom);
      p_valid <= 1'($urandom);
      for (int w = 0; w < 2; w++) begin
        wr_n <= w[0];
        @(negedge mclk);
        check(28'(psel_n), p ? 28'h1 : 28'h2);
        check(28'(dout[9:2]), 28'(hd_i[7:0]));
        check(28'(vvalid), 28'(w));
        @(posedge mclk);
      end
      lcd_n <= 1'b1;
      wr_n <= 1'b0;
      @(negedge mclk);
      check(28'(vvalid), 28'h1);
      @(posedge mclk);
      wr_n <= 1'b1;
      bb <= 1'b1;
      @(negedge mclk);
      check(28'({dout, vvalid}), 28'({p_data, p_valid}));
    end
    $display("test lcd route done");
    wreg(OSC_OFFSET, 16'h0001);
    @(posedge mclk);
    bb <= 1'b0;
    @(negedge mclk);
    check(28'(dout_oe_n), 28'h001);
    @(posedge mclk);
    bb <= 1'b1;
    @(negedge mclk);
    check(28'(dout_oe_n), 28'h3FF);
    load(OSC_OFFSET);
    rdat();
    wreg(OSC_OFFSET, 16'h0004);
    @(posedge mclk);
    p_clk <= 1'b1;
    p_fv <= 1'b1;
    @(negedge mclk);
    check(28'({vclk, fvalid}), 28'h1);
    // Split option, inverted polarity, enable waits for the frame gap
    wreg(OSC_OFFSET, 16'h001E);
    @(negedge mclk);
    check(28'(dout_oe_n), 28'h3FF);
    @(posedge mclk);
    p_fv <= 1'b0;
    @(posedge mclk);
    p_fv <= 1'b1;
    p_valid <= 1'b1;
    @(negedge mclk);
    check(28'(dout_oe_n), 28'h000);
    check(28'({vclk, vvalid}), 28'h1);
    @(posedge mclk);
    bs <= 1'b1;
    @(posedge mclk);
    bs <= 1'b0;
    @(negedge mclk);
    check(28'({vclk, vvalid}), 28'h2);
    wreg(OSC_OFFSET, 16'h0000);
    $display("test video control done");
    wreg(MODE_OFFSET, 16'h0001);
    pre = 1'b1;
    load(12'h300);
    repeat (3) rdat();
    wreg(MODE_OFFSET, 16'h0000);
    pre = 1'b0;
    $display("test pre-read done");
    stop_test();
  end
endmodule
